/* pcd_pkg.sv */
// Constants, register map and state types for the cable diagnostic bank.
// Assumes a 50 MHz core clock and 32-bit AHB-Lite register access.
package pcd_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PER_MS = CLK_HZ / 1000;
    // Bypass wait before forcing the link up, in milliseconds
    localparam int BYPASS_TIME_MS = 200;
    localparam logic [7:0] BYPASS_MS_CNT = 8'(BYPASS_TIME_MS);

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_VIEW_PAIR = 8'h16;
    localparam logic [7:0] IDX_SWING = 8'h1a;
    localparam logic [7:0] IDX_BYPASS = 8'h1b;
    localparam logic [7:0] IDX_CFT = 8'h1c;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
    localparam logic [9:0] ADDR_VIEW_PAIR = {IDX_VIEW_PAIR, 2'b00};
    localparam logic [9:0] ADDR_SWING = {IDX_SWING, 2'b00};
    localparam logic [9:0] ADDR_BYPASS = {IDX_BYPASS, 2'b00};
    localparam logic [9:0] ADDR_CFT = {IDX_CFT, 2'b00};
    localparam logic [9:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

    // ------------------------------------------------------------
    // Field values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] VIEW_BASET = 8'h00;
    localparam logic [7:0] VIEW_BASEX = 8'h01;
    localparam logic [7:0] RST_VIEW = 8'h00;
    localparam logic [2:0] RST_SWING = 3'h2;
    localparam logic [4:0] RST_SWING_RSVD = 5'h01;
    localparam logic [2:0] BYP_RO_TOP = 3'h4;
    localparam logic RST_BYP_EN = 1'b1;
    localparam logic [10:0] RST_BYP_RSVD = 11'h088;
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_SHORT = 2'h1;
    localparam logic [1:0] RES_OPEN = 2'h2;
    localparam logic [1:0] RES_FAIL = 2'h3;
    localparam logic [4:0] RST_MAG = 5'h00;
    localparam logic [7:0] RST_DIST = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BYP_EN_BIT = 12;
    localparam int BYP_STAT_BIT = 11;
    localparam int CFT_EN_BIT = 15;
    localparam int IRQ_CFT_BIT = 0;
    localparam int IRQ_BYP_BIT = 1;

    // ------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CFT_IDLE = 3'b001,
        CFT_RUN = 3'b010,
        CFT_HOLD = 3'b100
    } pcd_cft_state_t;

    typedef enum logic [2:0] {
        BYP_DOWN = 3'b001,
        BYP_TIMING = 3'b010,
        BYP_UP = 3'b100
    } pcd_byp_state_t;

endpackage

/* pcd_event_flag.sv */
// Sticky interrupt status bit, cleared by a write of one.
// Assumes set and clear are single-cycle pulses on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pcd_event_flag (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic setPulse,
    input wire logic clrPulse,
    output logic flag_r
);

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else if (setPulse) begin
            flag_r <= 1'b1;
        end else if (clrPulse) begin
            flag_r <= 1'b0;
        end
    end

endmodule // pcd_event_flag
`default_nettype wire

/* pcd_regs.sv */
// Management register bank: view select, output swing, BASE-X bypass
// and cable fault test result registers behind an AHB-Lite slave.
// Assumes the analog test engine and BASE-X logic share core_clk.
//
// Contract
// - View byte selects BASE-T or BASE-X view
// - Pair select picks diagnostic channel A to D
// - One write sets view and pair together
// - Three-bit swing code, reset code 010
// - Bypass enable forces link after 200 ms
// - Bypass status shows link came via timer
// - Test runs on enable, only link down
// - Test ignores far-end negotiation or pulses
// - Two-bit result: fail, open, short, none
// - Five-bit reflected magnitude, resets to zero
// - Eight-bit distance, host converts to meters
// - Distance zero when nothing found
`timescale 1ns/1ps
`default_nettype none
module pcd_regs
    import pcd_pkg::*;
#(
    parameter int P_CYCLES_PER_MS = CLK_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Configuration toward the transceiver core
    output logic viewBasex,
    output logic [2:0] swingCode,
    // BASE-X link control
    input wire logic basexSyncOk,
    input wire logic basexAnDone,
    output logic basexLinkUp,
    // Cable fault test engine
    input wire logic linkUp,
    input wire logic cftDone,
    input wire logic [7:0] cftStatusAll,
    input wire logic [19:0] cftMagAll,
    input wire logic [31:0] cftDistAll,
    output logic cftRun,
    // Interrupt
    output logic irq
);

    // --------------------
    // Storage
    // --------------------
    logic [7:0] viewSel_r; // View byte, low bits double as pair
    logic [2:0] swing_r; // Output amplitude code
    logic [4:0] swingRsvd_r; // Preserved reserved bits
    logic bypEn_r; // Bypass enable
    logic bypStat_r; // Link came up via bypass timer
    logic [10:0] bypRsvd_r; // Preserved reserved bits
    logic cftEn_r; // Test enable
    logic [7:0] resStat_r; // Latched status, two bits per pair
    logic [19:0] resMag_r; // Latched magnitude, five per pair
    logic [31:0] resDist_r; // Latched distance, eight per pair
    logic [1:0] irqMask_r; // Interrupt mask
    logic [1:0] irqStat; // Sticky interrupt flags
    pcd_cft_state_t cftState_r;
    pcd_byp_state_t bypState_r;
    // --------------------
    // Bus front end
    // --------------------
    logic addrValid; // Accepted address phase
    logic wrPend_r; // Write data phase pending
    logic [9:0] wrAddr_r; // Address of pending write
    logic wrView, wrSwing, wrByp, wrCft, wrStat, wrMask;
    logic [1:0] pairSel; // Channel under view
    logic [1:0] selStat; // Status of selected pair
    logic [4:0] selMag;
    logic [7:0] selDist;
    logic [31:0] rdMux; // Read value for the address phase
    logic cftEvent; // Test completed this cycle
    logic bypEvent; // Bypass timer expired this cycle

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrValid = hsel & hready & htrans[1] & (hsize == 3'h2);
    // Capture write address phase
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 10'h000;
        end else if (hready) begin
            wrPend_r <= addrValid & hwrite;
            wrAddr_r <= haddr[9:0];
        end
    end
    // Write strobes, valid only in the data phase
    always_comb begin
        wrView = 1'b0;
        wrSwing = 1'b0;
        wrByp = 1'b0;
        wrCft = 1'b0;
        wrStat = 1'b0;
        wrMask = 1'b0;
        if (!wrPend_r) begin
            wrView = 1'b0;
        end else if (wrAddr_r == ADDR_VIEW_PAIR) begin
            wrView = 1'b1;
        end else if (wrAddr_r == ADDR_SWING) begin
            wrSwing = 1'b1;
        end else if (wrAddr_r == ADDR_BYPASS) begin
            wrByp = 1'b1;
        end else if (wrAddr_r == ADDR_CFT) begin
            wrCft = 1'b1;
        end else if (wrAddr_r == ADDR_IRQ_STAT) begin
            wrStat = 1'b1;
        end else if (wrAddr_r == ADDR_IRQ_MASK) begin
            wrMask = 1'b1;
        end
    end
    // --------------------
    // View and pair select
    // --------------------
    // shared byte write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            viewSel_r <= RST_VIEW;
        end else if (wrView) begin
            viewSel_r <= hwdata[7:0];
        end
    end
    assign viewBasex = (viewSel_r == VIEW_BASEX);
    assign pairSel = viewSel_r[1:0];
    // --------------------
    // Output swing
    // --------------------
    // swing code store
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            swing_r <= RST_SWING;
            swingRsvd_r <= RST_SWING_RSVD;
        end else if (wrSwing) begin
            swing_r <= hwdata[2:0];
            swingRsvd_r <= hwdata[7:3];
        end
    end
    assign swingCode = swing_r;
    // --------------------
    // Bypass control
    // --------------------
    // reserved bits kept as written
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bypEn_r <= RST_BYP_EN;
            bypRsvd_r <= RST_BYP_RSVD;
        end else if (wrByp) begin
            bypEn_r <= hwdata[BYP_EN_BIT];
            bypRsvd_r <= hwdata[10:0];
        end
    end

    logic [$clog2(P_CYCLES_PER_MS)-1:0] msDiv_r; // Millisecond divider
    logic msTick; // One pulse per millisecond
    logic [7:0] msCnt_r; // Milliseconds while timing
    assign msTick = (msDiv_r == ($bits(msDiv_r))'(P_CYCLES_PER_MS - 1));

    // Divider runs only while the bypass timer is armed
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            msDiv_r <= '0;
            msCnt_r <= 8'h00;
        end else if (bypState_r != BYP_TIMING) begin
            msDiv_r <= '0;
            msCnt_r <= 8'h00;
        end else if (msTick) begin
            msDiv_r <= '0;
            msCnt_r <= msCnt_r + 8'h01;
        end else begin
            msDiv_r <= msDiv_r + 1'b1;
        end
    end

    assign bypEvent = (bypState_r == BYP_TIMING) && basexSyncOk &&
                      !basexAnDone && bypEn_r &&
                      (msCnt_r == BYPASS_MS_CNT);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bypState_r <= BYP_DOWN;
        end else begin
            case (bypState_r)
                BYP_DOWN: begin
                    if (basexSyncOk && basexAnDone) begin
                        bypState_r <= BYP_UP;
                    end else if (basexSyncOk && bypEn_r) begin
                        bypState_r <= BYP_TIMING;
                    end
                end
                BYP_TIMING: begin
                    if (!basexSyncOk || (!bypEn_r && !basexAnDone)) begin
                        bypState_r <= BYP_DOWN;
                    end else if (basexAnDone || bypEvent) begin
                        bypState_r <= BYP_UP;
                    end
                end
                BYP_UP: begin
                    if (!basexSyncOk) begin
                        bypState_r <= BYP_DOWN;
                    end
                end
                default: begin
                    bypState_r <= BYP_DOWN;
                end
            endcase
        end
    end
    assign basexLinkUp = (bypState_r == BYP_UP);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bypStat_r <= 1'b0;
        end else if (bypEvent) begin
            bypStat_r <= 1'b1;
        end else if (bypState_r != BYP_UP && basexSyncOk && basexAnDone) begin
            bypStat_r <= 1'b0;
        end
    end
    // --------------------
    // Cable fault test
    // --------------------
    // enable bit store
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cftEn_r <= 1'b0;
        end else if (wrCft) begin
            cftEn_r <= hwdata[CFT_EN_BIT];
        end
    end

    assign cftEvent = (cftState_r == CFT_RUN) && cftDone && cftEn_r &&
                      !linkUp;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cftState_r <= CFT_IDLE;
        end else begin
            case (cftState_r)
                CFT_IDLE: begin
                    if (cftEn_r && !linkUp) begin
                        cftState_r <= CFT_RUN;
                    end
                end
                CFT_RUN: begin
                    if (!cftEn_r || linkUp) begin
                        cftState_r <= CFT_IDLE;
                    end else if (cftDone) begin
                        cftState_r <= CFT_HOLD;
                    end
                end
                CFT_HOLD: begin
                    if (!cftEn_r) begin
                        cftState_r <= CFT_IDLE;
                    end
                end
                default: begin
                    cftState_r <= CFT_IDLE;
                end
            endcase
        end
    end
    assign cftRun = (cftState_r == CFT_RUN);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            resStat_r <= {4{RES_NONE}};
            resMag_r <= {4{RST_MAG}};
            resDist_r <= {4{RST_DIST}};
        end else if (cftEvent) begin
            resStat_r <= cftStatusAll;
            resMag_r <= cftMagAll;
            for (int p = 0; p < 4; p++) begin
                if (cftStatusAll[p*2 +: 2] == RES_NONE) begin
                    resDist_r[p*8 +: 8] <= RST_DIST;
                end else begin
                    resDist_r[p*8 +: 8] <= cftDistAll[p*8 +: 8];
                end
            end
        end
    end
    assign selStat = resStat_r[pairSel*2 +: 2];
    assign selMag = resMag_r[pairSel*5 +: 5];
    assign selDist = resDist_r[pairSel*8 +: 8];
    // --------------------
    // Interrupts
    // --------------------
    pcd_event_flag u_flagCft (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .setPulse(cftEvent),
        .clrPulse(wrStat & hwdata[IRQ_CFT_BIT]),
        .flag_r(irqStat[IRQ_CFT_BIT])
    );
    pcd_event_flag u_flagByp (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .setPulse(bypEvent),
        .clrPulse(wrStat & hwdata[IRQ_BYP_BIT]),
        .flag_r(irqStat[IRQ_BYP_BIT])
    );
    // Mask register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqMask_r <= 2'h0;
        end else if (wrMask) begin
            irqMask_r <= hwdata[1:0];
        end
    end
    assign irq = |(irqStat & irqMask_r);
    // --------------------
    // Read path
    // --------------------
    // Address decode for reads, unmapped reads as zero
    always_comb begin
        rdMux = 32'h0000_0000;
        if (haddr[9:0] == ADDR_VIEW_PAIR) begin
            rdMux = {24'h00_0000, viewSel_r};
        end else if (haddr[9:0] == ADDR_SWING) begin
            rdMux = {24'h00_0000, swingRsvd_r, swing_r};
        end else if (haddr[9:0] == ADDR_BYPASS) begin
            rdMux = {16'h0000, BYP_RO_TOP, bypEn_r, bypStat_r, bypRsvd_r};
        end else if (haddr[9:0] == ADDR_CFT) begin
            rdMux = {16'h0000, cftEn_r, selStat, selMag, selDist};
        end else if (haddr[9:0] == ADDR_IRQ_STAT) begin
            rdMux = {30'h0000_0000, irqStat};
        end else if (haddr[9:0] == ADDR_IRQ_MASK) begin
            rdMux = {30'h0000_0000, irqMask_r};
        end
    end
    // Read data registered at the address phase
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h0000_0000;
        end else if (addrValid && !hwrite) begin
            hrdata <= (haddr[31:10] == 22'h00_0000) ? rdMux : 32'h0000_0000;
        end
    end

endmodule // pcd_regs
`default_nettype wire

/* pcd_regs_checker.sv */
// Concurrent checks on the ports of the cable diagnostic register bank.
// Assumes one core_clk domain and asynchronous active-low rst_b.
`timescale 1ns/1ps
`default_nettype none
module pcd_regs_checker
    import pcd_pkg::*;
#(
    parameter int P_CYCLES_PER_MS = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic viewBasex,
    input wire logic [2:0] swingCode,
    input wire logic basexSyncOk,
    input wire logic basexAnDone,
    input wire logic basexLinkUp,
    input wire logic linkUp,
    input wire logic cftDone,
    input wire logic cftRun,
    input wire logic irq
);
    // --------------------
    // Helper logic
    // --------------------
    localparam int BYP_MIN = BYPASS_TIME_MS * P_CYCLES_PER_MS;
    logic acc; // Address phase taken
    logic wrQ_r; // Write in its data phase
    logic [31:0] addrQ_r; // Address of previous cycle
    logic [31:0] dataQ_r; // Data of previous cycle
    int syncCnt_r; // Cycles with sync held
    assign acc = hsel && hready && htrans[1] && (hsize == 3'h2);
    // Follow write data phases and sync duration
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrQ_r <= 1'b0;
            addrQ_r <= 32'h0;
            dataQ_r <= 32'h0;
            syncCnt_r <= 0;
        end else begin
            wrQ_r <= acc && hwrite;
            addrQ_r <= haddr;
            dataQ_r <= hwdata;
            if (!basexSyncOk) begin
                syncCnt_r <= 0;
            end else if (syncCnt_r < 100000) begin
                syncCnt_r <= syncCnt_r + 1;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // --------------------
    // Properties
    // --------------------
    property p_okay;
        hreadyout && !hresp;
    endproperty
    property p_view;
        wrQ_r && addrQ_r == 32'(ADDR_VIEW_PAIR) |=>
            viewBasex == (dataQ_r[7:0] == VIEW_BASEX);
    endproperty
    property p_swing;
        wrQ_r && addrQ_r == 32'(ADDR_SWING) |=> swingCode == dataQ_r[2:0];
    endproperty
    property p_hold;
        !(acc && !hwrite) |=> $stable(hrdata);
    endproperty
    property p_unmap;
        acc && !hwrite && haddr[31:10] != 22'h0 |=> hrdata == 32'h0;
    endproperty
    property p_start;
        $rose(cftRun) |-> !$past(linkUp);
    endproperty
    property p_stop;
        cftRun && (cftDone || linkUp) |=> !cftRun;
    endproperty
    property p_byp;
        $rose(basexLinkUp) && !basexAnDone |-> syncCnt_r >= BYP_MIN - 2;
    endproperty
    property p_loss;
        !basexSyncOk [*2] |=> !basexLinkUp;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not OKAY");
    a_view: assert property (p_view)
        else $error("view output wrong");
    a_swing: assert property (p_swing)
        else $error("swing code wrong");
    a_hold: assert property (p_hold)
        else $error("read data moved");
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    a_start: assert property (p_start)
        else $error("test started with link up");
    a_stop: assert property (p_stop)
        else $error("test still running");
    a_byp: assert property (p_byp)
        else $error("bypass link up too early");
    a_loss: assert property (p_loss)
        else $error("link kept up without sync");
    c_done: cover property (cftRun && cftDone);
    c_byp: cover property ($rose(basexLinkUp) && !basexAnDone);
    c_irq: cover property ($rose(irq));
endmodule // pcd_regs_checker

bind pcd_regs pcd_regs_checker #(.P_CYCLES_PER_MS(P_CYCLES_PER_MS)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .viewBasex(viewBasex), .swingCode(swingCode),
    .basexSyncOk(basexSyncOk), .basexAnDone(basexAnDone),
    .basexLinkUp(basexLinkUp), .linkUp(linkUp), .cftDone(cftDone),
    .cftRun(cftRun), .irq(irq)
);
`default_nettype wire

/* pcd_cft_engine_model.sv */
// Behavioural cable test engine feeding the bank's result inputs.
// Assumes cftRun is a level from the bank, sampled on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pcd_cft_engine_model #(
    parameter int P_DELAY = 12,
    parameter logic [7:0] P_ST = 8'h00,
    parameter logic [19:0] P_MAG = 20'h0,
    parameter logic [31:0] P_DIST = 32'h0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cftRun,
    output logic cftDone,
    output logic [7:0] cftStatusAll,
    output logic [19:0] cftMagAll,
    output logic [31:0] cftDistAll
);
    int cnt; // Cycles spent measuring
    // Completes whatever the far end does
    // Results stand only in the done cycle, else a toggling pattern
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            cftDone <= 1'b0;
            cftStatusAll <= 8'h00;
            cftMagAll <= 20'h0;
            cftDistAll <= 32'h0;
        end else if (cftRun && !cftDone && cnt == P_DELAY) begin
            cnt <= 0;
            cftDone <= 1'b1;
            cftStatusAll <= P_ST;
            cftMagAll <= P_MAG;
            cftDistAll <= P_DIST;
        end else begin
            cnt <= (cftRun && !cftDone) ? cnt + 1 : 0;
            cftDone <= 1'b0;
            cftStatusAll <= ~cftStatusAll;
            cftMagAll <= ~cftMagAll;
            cftDistAll <= ~cftDistAll;
        end
    end
endmodule // pcd_cft_engine_model
`default_nettype wire

/* pcd_regs_bench.sv */
// Self-checking bench for the cable diagnostic register bank.
// Assumes the engine model and bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module pcd_regs_bench import pcd_pkg::*; ;
    localparam int P_MS = 4; // Shortened millisecond
    localparam logic [7:0] ST = 8'he4; // D fail, C open, B short, A none
    localparam logic [19:0] MAG = {5'h0a, 5'h1f, 5'h10, 5'h00};
    localparam logic [31:0] DIST = 32'h80ff1255;
    localparam logic [31:0] A_VIEW = 32'(ADDR_VIEW_PAIR),
        A_SW = 32'(ADDR_SWING), A_BYP = 32'(ADDR_BYPASS),
        A_CFT = 32'(ADDR_CFT), A_ST = 32'(ADDR_IRQ_STAT),
        A_MSK = 32'(ADDR_IRQ_MASK);
    logic core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic linkUp = 1'b1, basexSyncOk = 1'b0, basexAnDone = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, swingCode;
    logic hreadyout, hresp, viewBasex, basexLinkUp, cftDone, cftRun, irq;
    logic [7:0] stAll; // Engine status lines
    logic [19:0] magAll; // Engine magnitude lines
    logic [31:0] distAll; // Engine distance lines
    int errorCnt = 0, checks = 0;
    always #10 core_clk = ~core_clk;
    pcd_regs #(.P_CYCLES_PER_MS(P_MS)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .viewBasex(viewBasex),
        .swingCode(swingCode), .basexSyncOk(basexSyncOk),
        .basexAnDone(basexAnDone), .basexLinkUp(basexLinkUp),
        .linkUp(linkUp), .cftDone(cftDone), .cftStatusAll(stAll),
        .cftMagAll(magAll), .cftDistAll(distAll), .cftRun(cftRun),
        .irq(irq));
    pcd_cft_engine_model #(.P_ST(ST), .P_MAG(MAG), .P_DIST(DIST)) u_eng (
        .core_clk(core_clk), .rst_b(rst_b), .cftRun(cftRun),
        .cftDone(cftDone), .cftStatusAll(stAll), .cftMagAll(magAll),
        .cftDistAll(distAll));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One single AHB-Lite word transfer, held until hready
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] q);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic waitNeg(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Expected test word of pair p
    function automatic logic [31:0] expCft(input int p);
        logic [1:0] s;
        s = ST[2*p+:2];
        return {16'h0, 1'b1, s, MAG[5*p+:5],
                (s == RES_NONE) ? 8'h00 : DIST[8*p+:8]};
    endfunction
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        errorCnt++;
        $display("[ERR] %0t watchdog expired", $time);
        printVerdict();
    end
    // --------------------
    // Test sequence
    // --------------------
    initial begin
        int n;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(A_VIEW, 32'h0);
        rd(A_SW, 32'h0a);
        rd(A_BYP, 32'h9088);
        rd(A_CFT, 32'h0);
        rd(A_ST, 32'h0);
        rd(A_MSK, 32'h0);
        rd(32'h3fc, 32'h0);
        rd(32'h458, 32'h0);
        waitNeg(1);
        chk({29'h0, swingCode}, 32'h2);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wr(A_SW, 32'h08 | 32'(c));
            rd(A_SW, 32'h08 | 32'(c));
            chk({29'h0, swingCode}, 32'(c));
        end
        $display("test swing done");
        wr(A_MSK, 32'h3);
        wr(A_CFT, 32'h8000);
        waitNeg(5);
        chk({31'h0, cftRun}, 32'h0);
        wr(A_CFT, 32'h0);
        @(posedge core_clk) linkUp <= 1'b0;
        wr(A_CFT, 32'h8000);
        waitNeg(3);
        chk({31'h0, cftRun}, 32'h1);
        @(posedge core_clk) linkUp <= 1'b1;
        waitNeg(2);
        chk({31'h0, cftRun}, 32'h0);
        rd(A_CFT, 32'h8000);
        wr(A_CFT, 32'h0);
        @(posedge core_clk) linkUp <= 1'b0;
        wr(A_CFT, 32'h8000);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            waitNeg(1);
            n++;
        end
        chk({30'h0, cftRun, irq}, 32'h1);
        for (int p = 0; p < 4; p++) begin
            wr(A_VIEW, 32'hab00 | 32'(p));
            rd(A_VIEW, 32'(p));
            chk({31'h0, viewBasex}, 32'(p == 1));
            rd(A_CFT, expCft(p));
        end
        rd(A_ST, 32'h1);
        wr(A_MSK, 32'h0);
        waitNeg(1);
        chk({31'h0, irq}, 32'h0);
        wr(A_MSK, 32'h3);
        waitNeg(1);
        chk({31'h0, irq}, 32'h1);
        wr(A_ST, 32'h1);
        waitNeg(1);
        chk({31'h0, irq}, 32'h0);
        wr(A_CFT, 32'h0);
        $display("test cable done");
        @(posedge core_clk) basexSyncOk <= 1'b1;
        n = 0;
        while (basexLinkUp !== 1'b1 && n < 1000) begin
            waitNeg(1);
            n++;
        end
        chk(32'(n >= 800 && n <= 806), 32'h1);
        rd(A_BYP, 32'h9888);
        rd(A_ST, 32'h2);
        wr(A_ST, 32'h2);
        @(posedge core_clk) basexSyncOk <= 1'b0;
        waitNeg(3);
        chk({31'h0, basexLinkUp}, 32'h0);
        rd(A_BYP, 32'h9888);
        @(posedge core_clk) basexAnDone <= 1'b1;
        basexSyncOk <= 1'b1;
        waitNeg(5);
        chk({31'h0, basexLinkUp}, 32'h1);
        rd(A_BYP, 32'h9088);
        @(posedge core_clk) basexAnDone <= 1'b0;
        basexSyncOk <= 1'b0;
        wr(A_BYP, 32'h8088);
        @(posedge core_clk) basexSyncOk <= 1'b1;
        waitNeg(900);
        chk({31'h0, basexLinkUp}, 32'h0);
        rd(A_BYP, 32'h8088);
        $display("test bypass done");
        printVerdict();
    end
endmodule // pcd_regs_bench
`default_nettype wire
